// ==== inc/spc_pkg.sv ====
// Package for the self-programming control unit
package spc_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] SPC_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SPC_PTR_OFF    = 8'h04;
  localparam logic [7:0] SPC_DATA_OFF   = 8'h08;
  localparam logic [7:0] SPC_INSTR_OFF  = 8'h0c;
  localparam logic [7:0] SPC_RESULT_OFF = 8'h10;
  localparam logic [7:0] SPC_STATUS_OFF = 8'h14;
  // Control register fields
  localparam int SPC_BIT_EN     = 0;
  localparam int SPC_BIT_RWW    = 6;
  localparam logic [5:0] SPC_CMD_SIG   = 6'h21;
  localparam logic [5:0] SPC_CMD_CLR   = 6'h11;
  localparam logic [5:0] SPC_CMD_FUSE  = 6'h09;
  localparam logic [5:0] SPC_CMD_WRITE = 6'h05;
  localparam logic [5:0] SPC_CMD_ERASE = 6'h03;
  localparam logic [5:0] SPC_CMD_LOAD  = 6'h01;
  localparam logic [7:0] SPC_CTRL_RST  = 8'h00;
  // Instruction trigger codes
  localparam logic [1:0] SPC_INSTR_STORE = 2'h1;
  localparam logic [1:0] SPC_INSTR_LOAD  = 2'h2;
  // Issue windows in cycles
  localparam logic [2:0] SPC_STORE_WIN = 3'd4;
  localparam logic [2:0] SPC_LOAD_WIN  = 3'd3;
  // Flash operation time
  localparam int    SPC_CLK_MHZ     = 250;
  localparam int    SPC_OP_MIN_US   = 3700;
  localparam int    SPC_OP_MAX_US   = 4500;
  localparam int    SPC_OP_CYC      = SPC_OP_MIN_US * SPC_CLK_MHZ;
  // Page geometry
  localparam int SPC_WORD_BITS = 6;
  localparam int SPC_PAGE_WORDS = 64;
  localparam int SPC_PAGE_BITS = 7;
  localparam logic [15:0] SPC_ERASED = 16'hffff;
  // Pointer values for fuse and signature reads
  localparam logic [2:0] SPC_PTR_0 = 3'h0;
  localparam logic [2:0] SPC_PTR_1 = 3'h1;
  localparam logic [2:0] SPC_PTR_2 = 3'h2;
  localparam logic [2:0] SPC_PTR_3 = 3'h3;
  localparam logic [2:0] SPC_PTR_4 = 3'h4;
  localparam logic [2:0] SPC_PTR_5 = 3'h5;
  // Bus responses
  localparam logic [1:0] SPC_RESP_OK  = 2'b00;
  localparam logic [1:0] SPC_RESP_ERR = 2'b10;
endpackage : spc_pkg

// ==== core/spc_page_buf.sv ====
// Temporary page buffer of the self-programming unit
`timescale 1ns/1ps
module spc_page_buf
  import spc_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     clr,
  input  wire logic                     wr,
  input  wire logic [SPC_WORD_BITS-1:0] waddr,
  input  wire logic [15:0]              wdata,
  input  wire logic [SPC_WORD_BITS-1:0] raddr,
  output logic      [15:0]              rdata
);
  logic [15:0] mem_q [SPC_PAGE_WORDS];

  // Per-word storage; reset or clear returns every word to erased state
  for (genvar i = 0; i < SPC_PAGE_WORDS; i++) begin : g_word
    always_ff @(posedge core_clk) begin
      if (rst || clr) begin
        mem_q[i] <= SPC_ERASED;
      end else if (wr && waddr == SPC_WORD_BITS'(i)) begin
        mem_q[i] <= wdata;
      end
    end
  end

  assign rdata = mem_q[raddr];
endmodule : spc_page_buf

// ==== core/spc_ctrl.sv ====
// Self-programming control unit with AXI4-Lite register access
//
// Contract
// - Read-while-write busy bit always reads zero
// - Signature read: load returns byte, store ignored
// - Clear command empties the whole page buffer
// - Fuse read returns lock or fuse by pointer
// - Page write programs page from buffer
// - Page write bit self-clears; core stalled meanwhile
// - Page erase erases pointer page, stalls core
// - Page erase bit self-clears on end or timeout
// - Enable opens store window of four cycles
// - Plain enable stores data word into buffer
// - Enable clears after store, stays during operation
// - Six recognised command patterns decoded
// - EEPROM write blocks programming and fuse reads
// - Lock bits at pointer one, bits one-zero
// - Fuse read bits clear on completion or timeout
// - Fuse bytes low, high, extended by pointer
// - Programmed bits read zero, unprogrammed one
// - Signature row pointer map
// - Signature bits clear on read or timeout
// - Flash operation completes despite reset
// - Erase and write last the minimum time
// - Buffer erased after page write and reset
// - Store instruction needs self-program fuse programmed
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module spc_ctrl
  import spc_pkg::*;
#(
  parameter int OP_CYCLES = SPC_OP_CYC,
  parameter logic [7:0] SIG_BYTE0 = 8'h11, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h22, // Arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h33  // Arbitrary identity value
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        eeprom_write_busy,
  input  wire logic [7:0]  fuse_low_byte,
  input  wire logic [7:0]  fuse_high_byte,
  input  wire logic [7:0]  fuse_ext_byte,
  input  wire logic [1:0]  lock_bits,
  input  wire logic [7:0]  osc_cal_byte,
  input  wire logic [7:0]  temp_sensor_offset,
  input  wire logic [7:0]  temp_sensor_gain,
  output logic             core_stall,
  output logic             flash_erase,
  output logic             flash_write,
  output logic [SPC_PAGE_BITS-1:0] flash_page,
  output logic [15:0]      flash_wdata,
  output logic [SPC_WORD_BITS-1:0] flash_waddr
);
  typedef enum logic [1:0] {SPC_IDLE, SPC_ERASE, SPC_WRITE, SPC_WDUMP} spc_op_e;

  logic [5:0]  cmd_q;
  logic [2:0]  win_q;
  logic [15:0] ptr_q, data_q;
  logic [7:0]  result_q;
  spc_op_e     op_q;
  logic [31:0] op_cnt_q;
  logic [SPC_WORD_BITS-1:0] dump_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        instr_ok_q, ctrl_hit_q;
  logic [1:0]  instr_q;
  logic        buf_wr, buf_clr, buf_rst;
  logic [15:0] buf_rdata;
  logic        do_wr, store_go, load_go, op_busy;
  logic [7:0]  ctrl_rd, rd_word;
  logic        self_prog_fuse;

  assign self_prog_fuse = fuse_ext_byte[0];
  assign op_busy = (op_q != SPC_IDLE);

  // Write channel: address and data taken in either order
  assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SPC_RESP_OK;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0;
      wstrb0_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb0_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q <= SPC_INSTR_OFF) ? SPC_RESP_OK : SPC_RESP_ERR;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Accepted write strobes for the command logic
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_hit_q <= 1'b0;
      instr_ok_q <= 1'b0;
      instr_q    <= 2'h0;
    end else begin
      // Control writes are dropped while an EEPROM write runs or an op is busy
      ctrl_hit_q <= do_wr && wstrb0_q && awaddr_q == SPC_CTRL_OFF &&
                    !eeprom_write_busy && !op_busy;
      instr_ok_q <= do_wr && wstrb0_q && awaddr_q == SPC_INSTR_OFF;
      instr_q    <= wdata_q[1:0];
    end
  end

  // Pointer and data registers stand in for Z and R0
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_q  <= 16'h0;
      data_q <= 16'h0;
    end else if (do_wr && awaddr_q == SPC_PTR_OFF) begin
      ptr_q <= wdata_q[15:0];
    end else if (do_wr && awaddr_q == SPC_DATA_OFF) begin
      data_q <= wdata_q[15:0];
    end
  end

  assign store_go = instr_ok_q && instr_q == SPC_INSTR_STORE && cmd_q[SPC_BIT_EN] &&
                    win_q != 3'd0 && !op_busy && !self_prog_fuse && !eeprom_write_busy;
  // Loads only in the first three cycles of the four-cycle window
  assign load_go  = instr_ok_q && instr_q == SPC_INSTR_LOAD && cmd_q[SPC_BIT_EN] &&
                    win_q > SPC_STORE_WIN - SPC_LOAD_WIN && !eeprom_write_busy;

  // Command register and issue window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_q <= SPC_CTRL_RST[5:0];
      win_q <= 3'd0;
    end else if (ctrl_hit_q) begin
      unique case (wdata_q[5:0])
        SPC_CMD_SIG, SPC_CMD_CLR, SPC_CMD_FUSE, SPC_CMD_WRITE,
        SPC_CMD_ERASE, SPC_CMD_LOAD: begin
          cmd_q <= wdata_q[5:0];
          win_q <= SPC_STORE_WIN;
        end
        default: begin
          cmd_q <= 6'h00;
          win_q <= 3'd0;
        end
      endcase
    end else if (op_busy) begin
      // Enable and op bit stay up until the flash operation ends
      if (op_q != SPC_WDUMP && op_cnt_q == 32'd1) begin
        cmd_q <= 6'h00;
      end
    end else if (store_go) begin
      if (cmd_q != SPC_CMD_ERASE && cmd_q != SPC_CMD_WRITE) begin
        cmd_q <= 6'h00;
      end
      win_q <= 3'd0;
    end else if (load_go && (cmd_q == SPC_CMD_SIG || cmd_q == SPC_CMD_FUSE)) begin
      cmd_q <= 6'h00;
      win_q <= 3'd0;
    end else if (win_q != 3'd0) begin
      win_q <= win_q - 3'd1;
      // Reads have a shorter window; all bits drop together on expiry
      if (win_q == 3'd1 ||
          (win_q == SPC_STORE_WIN - SPC_LOAD_WIN + 3'd1 &&
           (cmd_q == SPC_CMD_SIG || cmd_q == SPC_CMD_FUSE))) begin
        cmd_q <= 6'h00;
        win_q <= 3'd0;
      end
    end
  end

  // Flash operation sequencer; runs on across reset so a write finishes
  always_ff @(posedge core_clk) begin
    case (op_q)
      SPC_IDLE: begin
        if (store_go && cmd_q == SPC_CMD_ERASE) begin
          op_q     <= SPC_ERASE;
          op_cnt_q <= 32'(OP_CYCLES);
        end else if (store_go && cmd_q == SPC_CMD_WRITE) begin
          op_q     <= SPC_WDUMP;
          dump_q   <= '0;
          op_cnt_q <= 32'(OP_CYCLES);
        end
      end
      SPC_WDUMP: begin
        dump_q <= dump_q + SPC_WORD_BITS'(1);
        if (dump_q == SPC_WORD_BITS'(SPC_PAGE_WORDS - 1)) begin
          op_q <= SPC_WRITE;
        end
      end
      SPC_ERASE, SPC_WRITE: begin
        op_cnt_q <= op_cnt_q - 32'd1;
        if (op_cnt_q == 32'd1) begin
          op_q <= SPC_IDLE;
        end
      end
      default: op_q <= SPC_IDLE;
    endcase
  end

  // Flash array strobes; page from upper pointer bits, data words from buffer
  always_ff @(posedge core_clk) begin
    if (rst && !op_busy) begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page  <= '0;
      flash_wdata <= 16'h0;
      flash_waddr <= '0;
      core_stall  <= 1'b0;
    end else begin
      core_stall  <= op_busy || store_go;
      flash_erase <= store_go && cmd_q == SPC_CMD_ERASE;
      flash_write <= op_q == SPC_WDUMP;
      flash_wdata <= buf_rdata;
      flash_waddr <= dump_q;
      if (store_go) begin
        flash_page <= ptr_q[SPC_WORD_BITS+SPC_PAGE_BITS:SPC_WORD_BITS+1];
      end
    end
  end

  // Buffer load ignores pointer bit 0; clear on command, after write, at reset
  assign buf_wr  = store_go && cmd_q == SPC_CMD_LOAD && !eeprom_write_busy;
  assign buf_clr = (store_go && cmd_q == SPC_CMD_CLR) ||
                   (op_q == SPC_WRITE && op_cnt_q == 32'd1);
  // Reset spares the buffer mid-dump; the write's end clears it anyway
  assign buf_rst = rst && op_q != SPC_WDUMP;

  spc_page_buf u_buf (
    .core_clk (core_clk),
    .rst      (buf_rst),
    .clr      (buf_clr),
    .wr       (buf_wr),
    .waddr    (ptr_q[SPC_WORD_BITS:1]),
    .wdata    (data_q),
    .raddr    (dump_q),
    .rdata    (buf_rdata)
  );

  // Load result: signature row, fuse or lock bytes; stored polarity as-is
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_q <= 8'h00;
    end else if (load_go && cmd_q == SPC_CMD_SIG) begin
      case (ptr_q[2:0])
        SPC_PTR_0: result_q <= SIG_BYTE0;
        SPC_PTR_2: result_q <= SIG_BYTE1;
        SPC_PTR_4: result_q <= SIG_BYTE2;
        SPC_PTR_1: result_q <= osc_cal_byte;
        SPC_PTR_3: result_q <= temp_sensor_offset;
        SPC_PTR_5: result_q <= temp_sensor_gain;
        default:   result_q <= 8'h00;
      endcase
    end else if (load_go && cmd_q == SPC_CMD_FUSE) begin
      case (ptr_q[1:0])
        SPC_PTR_0[1:0]: result_q <= fuse_low_byte;
        SPC_PTR_1[1:0]: result_q <= {6'h3f, lock_bits};
        SPC_PTR_2[1:0]: result_q <= {7'h7f, fuse_ext_byte[0]};
        default:        result_q <= fuse_high_byte;
      endcase
    end
  end

  // Control readback: busy bit fixed at zero
  assign ctrl_rd = {1'b0, 1'b0, cmd_q};

  always_comb begin
    case (s_axi_araddr)
      SPC_CTRL_OFF:   rd_word = ctrl_rd;
      SPC_RESULT_OFF: rd_word = result_q;
      SPC_STATUS_OFF: rd_word = {6'h00, eeprom_write_busy, op_busy};
      default:        rd_word = 8'h00;
    endcase
  end

  // Read channel; pointer and data words read back in full
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= SPC_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= (s_axi_araddr == SPC_PTR_OFF)  ? {16'h0, ptr_q} :
                       (s_axi_araddr == SPC_DATA_OFF) ? {16'h0, data_q} : {24'h0, rd_word};
      s_axi_rresp   <= (s_axi_araddr <= SPC_STATUS_OFF && s_axi_araddr[1:0] == 2'b00 &&
                        s_axi_araddr != SPC_INSTR_OFF) ? SPC_RESP_OK : SPC_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : spc_ctrl

// ==== bench/spc_ctrl_chk.sv ====
// Port checks for the self-programming control unit
`timescale 1ns/1ps
module spc_ctrl_chk
  import spc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        eeprom_write_busy,
  input wire logic [7:0]  fuse_ext_byte,
  input wire logic        core_stall,
  input wire logic        flash_erase,
  input wire logic        flash_write,
  input wire logic [SPC_PAGE_BITS-1:0] flash_page
);
  logic [7:0] ra_q;
  logic [6:0] wcnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end
  // Not reset: a page write runs on through reset
  always_ff @(posedge core_clk) begin
    wcnt_q <= core_stall ? wcnt_q + 7'(flash_write) : 7'h00;
  end
  AST_RWW_ZERO: assert property (s_axi_rvalid && ra_q == SPC_CTRL_OFF |->
    s_axi_rdata[7:6] == 2'b00) else $error("control upper bits not zero");
  AST_ERASE_ONCE: assert property (flash_erase |=> !flash_erase [*8])
    else $error("erase restarted during erase");
  AST_ERASE_STALL: assert property (flash_erase |-> ##[0:1] core_stall)
    else $error("erase without stall");
  AST_WRITE_STALL: assert property (flash_write |-> core_stall || $past(core_stall))
    else $error("page write without stall");
  AST_WRITE_PAGE: assert property (flash_write && $past(flash_write) |-> $stable(flash_page))
    else $error("page changed within write");
  AST_WRITE_MAX: assert property (flash_write |-> wcnt_q < 7'h40)
    else $error("more words than a page");
  AST_NO_MIX: assert property (!(flash_erase && flash_write))
    else $error("erase and write together");
  AST_EE_BLOCK: assert property (eeprom_write_busy [*8] |-> !flash_erase)
    else $error("erase started during eeprom write");
  AST_FUSE_GATE: assert property (fuse_ext_byte[0] [*8] |-> !flash_erase)
    else $error("erase with self-program fuse clear");
  AST_ERR_DATA: assert property (s_axi_rvalid && s_axi_rresp == SPC_RESP_ERR |->
    s_axi_rdata == 32'h0) else $error("error read with data");
  cover property (flash_erase);
  cover property (flash_write && flash_page == 7'h05);
  cover property (s_axi_rvalid && s_axi_rresp == SPC_RESP_ERR);
endmodule : spc_ctrl_chk

bind spc_ctrl spc_ctrl_chk i_chk (
  .core_clk(core_clk), .rst(rst), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .eeprom_write_busy(eeprom_write_busy), .fuse_ext_byte(fuse_ext_byte),
  .core_stall(core_stall), .flash_erase(flash_erase), .flash_write(flash_write),
  .flash_page(flash_page));

// ==== bench/spc_flash_mdl.sv ====
// Flash array, fuse, lock and signature storage behind the unit
`timescale 1ns/1ps
module spc_flash_mdl
  import spc_pkg::*;
#(
  parameter logic [7:0] FLO = 8'hff,
  parameter logic [7:0] FHI = 8'hff,
  parameter logic [1:0] LKB = 2'h3,
  parameter logic [7:0] OSC = 8'h80,
  parameter logic [7:0] TSO = 8'h00,
  parameter logic [7:0] TSG = 8'h00
) (
  input  wire logic                     core_clk,
  input  wire logic                     flash_erase,
  input  wire logic                     flash_write,
  input  wire logic [SPC_PAGE_BITS-1:0] flash_page,
  input  wire logic [15:0]              flash_wdata,
  input  wire logic [SPC_WORD_BITS-1:0] flash_waddr,
  output logic      [7:0]               fuse_low_byte,
  output logic      [7:0]               fuse_high_byte,
  output logic      [1:0]               lock_bits,
  output logic      [7:0]               osc_cal_byte,
  output logic      [7:0]               temp_sensor_offset,
  output logic      [7:0]               temp_sensor_gain
);
  logic [15:0] mem [SPC_PAGE_WORDS];
  logic [SPC_PAGE_BITS-1:0] pg = '0;
  int n_wr = 0;
  int n_er = 0;
  // Stored as read: zero means programmed
  assign fuse_low_byte = FLO;
  assign fuse_high_byte = FHI;
  assign lock_bits = LKB;
  assign osc_cal_byte = OSC;
  assign temp_sensor_offset = TSO;
  assign temp_sensor_gain = TSG;
  // Keeps only the last page written; enough to compare one page at a time
  always @(posedge core_clk) begin
    if (flash_erase === 1'b1) begin
      n_er <= n_er + 1;
      pg <= flash_page;
    end
    if (flash_write === 1'b1) begin
      n_wr <= n_wr + 1;
      pg <= flash_page;
      mem[flash_waddr] <= flash_wdata;
    end
  end
endmodule : spc_flash_mdl

// ==== bench/spc_ctrl_tb.sv ====
// Self-checking bench for the self-programming control unit
`timescale 1ns/1ps
module spc_ctrl_tb;
  import spc_pkg::*;
  localparam logic [7:0] SGA = 8'h5a; // Arbitrary identity value
  localparam logic [7:0] SGB = 8'h6b; // Arbitrary identity value
  localparam logic [7:0] SGC = 8'h7c; // Arbitrary identity value
  localparam logic [7:0] FLO = 8'h62;
  localparam logic [7:0] FHI = 8'hd9;
  localparam logic [1:0] LKB = 2'h2;
  localparam logic [7:0] SIGS [6] = '{SGA, 8'h91, SGB, 8'h3e, SGC, 8'hc4};
  localparam logic [7:0] NOP [4] = '{8'h07, 8'h21, 8'h09, 8'h3f};
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        ee_busy = 1'b0;
  logic [7:0]  fext = 8'hfe;
  logic        awready, wready, bvalid, arready, rvalid, stall, f_er, f_wr;
  logic [1:0]  bresp, rresp, rr, br;
  logic [31:0] rdata, rd;
  logic [7:0]  flo, fhi, osc, tso, tsg;
  logic [1:0]  lkb;
  logic [SPC_PAGE_BITS-1:0] f_pg;
  logic [SPC_WORD_BITS-1:0] f_wa;
  logic [15:0] f_wd;
  int fails = 0;
  int n_checks = 0;
  int exp_wr = 0;
  always #2 core_clk = ~core_clk;
  spc_ctrl #(.OP_CYCLES(20), .SIG_BYTE0(SGA), .SIG_BYTE1(SGB), .SIG_BYTE2(SGC)) i_dut (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .eeprom_write_busy(ee_busy), .fuse_low_byte(flo), .fuse_high_byte(fhi),
    .fuse_ext_byte(fext), .lock_bits(lkb), .osc_cal_byte(osc), .temp_sensor_offset(tso),
    .temp_sensor_gain(tsg), .core_stall(stall), .flash_erase(f_er), .flash_write(f_wr),
    .flash_page(f_pg), .flash_wdata(f_wd), .flash_waddr(f_wa));
  spc_flash_mdl #(.FLO(FLO), .FHI(FHI), .LKB(LKB), .OSC(SIGS[1]), .TSO(SIGS[3]),
    .TSG(SIGS[5])) i_flash (
    .core_clk(core_clk), .flash_erase(f_er), .flash_write(f_wr), .flash_page(f_pg),
    .flash_wdata(f_wd), .flash_waddr(f_wa), .fuse_low_byte(flo), .fuse_high_byte(fhi),
    .lock_bits(lkb), .osc_cal_byte(osc), .temp_sensor_offset(tso), .temp_sensor_gain(tsg));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic tmo;
    fails++;
    stop_test();
  endtask : tmo
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Address and data offered together; each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    br = bresp;
    if (i == 60) tmo();
  endtask : axw
  task automatic axr(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rr = rresp;
    if (i == 60) tmo();
  endtask : axr
  task automatic cmd(input logic [15:0] p, input logic [7:0] c, input logic [1:0] ins);
    axw(SPC_PTR_OFF, {16'h0, p});
    axw(SPC_CTRL_OFF, {24'h0, c});
    axw(SPC_INSTR_OFF, {30'h0, ins});
    repeat (3) @(posedge core_clk);
  endtask : cmd
  // One operation at a time, and no control write while the eeprom is busy
  task automatic wait_idle;
    int i;
    for (i = 0; i < 100; i++) begin
      axr(SPC_STATUS_OFF);
      if (rd[1:0] === 2'b00) break;
    end
    if (i == 100) tmo();
  endtask : wait_idle
  task automatic page_write;
    cmd(16'h0280, {2'b0, SPC_CMD_WRITE}, SPC_INSTR_STORE);
    axr(SPC_CTRL_OFF);
    chk("ctrl_writing", 32'h5, {29'h0, rd[2:0]});
    wait_idle();
    exp_wr += 64;
    chk("words", exp_wr, i_flash.n_wr);
    chk("page", 32'h5, {25'h0, i_flash.pg});
  endtask : page_write
  initial begin : main
    int p;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    axr(SPC_CTRL_OFF);
    chk("ctrl_idle", 32'h0, rd);
    axr(8'h18);
    chk("unmapped", {30'h0, SPC_RESP_ERR}, {30'h0, rr});
    axw(8'h18, 32'h0);
    chk("bresp_unmapped", {30'h0, SPC_RESP_ERR}, {30'h0, br});
    for (p = 0; p < 4; p++) begin
      cmd(p[15:0], {2'b0, SPC_CMD_FUSE}, SPC_INSTR_LOAD);
      axr(SPC_RESULT_OFF);
      case (p)
        0: chk("fuse_low", FLO, rd[7:0]);
        1: chk("lock", LKB, rd[1:0]);
        2: chk("fuse_ext", fext[0], rd[0]);
        default: chk("fuse_high", FHI, rd[7:0]);
      endcase
    end
    for (p = 0; p < 6; p++) begin
      cmd(p[15:0], {2'b0, SPC_CMD_SIG}, SPC_INSTR_LOAD);
      axr(SPC_RESULT_OFF);
      chk("sig", SIGS[p], rd[7:0]);
    end
    axw(SPC_DATA_OFF, 32'h0000beef);
    chk("bresp_ok", {30'h0, SPC_RESP_OK}, {30'h0, br});
    cmd(16'h0295, {2'b0, SPC_CMD_LOAD}, SPC_INSTR_STORE);
    axw(SPC_DATA_OFF, 32'h00001234);
    cmd(16'h02fe, {2'b0, SPC_CMD_LOAD}, SPC_INSTR_STORE);
    page_write();
    chk("word_10", 32'hbeef, i_flash.mem[10]);
    chk("word_63", 32'h1234, i_flash.mem[63]);
    chk("word_0", 32'hffff, i_flash.mem[0]);
    page_write();
    chk("word_10_again", 32'hffff, i_flash.mem[10]);
    axw(SPC_DATA_OFF, 32'h00004321);
    cmd(16'h0295, {2'b0, SPC_CMD_LOAD}, SPC_INSTR_STORE);
    cmd(16'h0000, {2'b0, SPC_CMD_CLR}, SPC_INSTR_STORE);
    page_write();
    chk("cleared", 32'hffff, i_flash.mem[10]);
    // Reset pulse in the middle of a page write; the write must finish intact
    axw(SPC_DATA_OFF, 32'h00005678);
    cmd(16'h0295, {2'b0, SPC_CMD_LOAD}, SPC_INSTR_STORE);
    cmd(16'h0280, {2'b0, SPC_CMD_WRITE}, SPC_INSTR_STORE);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    wait_idle();
    exp_wr += 64;
    chk("words_rst", exp_wr, i_flash.n_wr);
    chk("word_10_rst", 32'h5678, i_flash.mem[10]);
    chk("page_rst", 32'h5, {25'h0, i_flash.pg});
    cmd(16'h0300, {2'b0, SPC_CMD_ERASE}, SPC_INSTR_STORE);
    axr(SPC_CTRL_OFF);
    chk("ctrl_erasing", 32'h3, {30'h0, rd[1:0]});
    wait_idle();
    chk("erases", 32'h1, i_flash.n_er);
    chk("erase_page", 32'h6, {25'h0, i_flash.pg});
    axr(SPC_CTRL_OFF);
    chk("ctrl_done", 32'h0, rd);
    axw(SPC_CTRL_OFF, {26'h0, SPC_CMD_WRITE});
    repeat (10) @(posedge core_clk);
    axr(SPC_CTRL_OFF);
    chk("ctrl_expired", 32'h0, rd);
    axw(SPC_INSTR_OFF, {30'h0, SPC_INSTR_STORE});
    for (p = 0; p < 4; p++) begin
      cmd(16'h0280, NOP[p], SPC_INSTR_STORE);
    end
    ee_busy <= 1'b1;
    cmd(16'h0280, {2'b0, SPC_CMD_ERASE}, SPC_INSTR_STORE);
    ee_busy <= 1'b0;
    fext <= 8'hff;
    cmd(16'h0280, {2'b0, SPC_CMD_ERASE}, SPC_INSTR_STORE);
    fext <= 8'hfe;
    repeat (8) @(posedge core_clk);
    chk("no_erase", 32'h1, i_flash.n_er);
    chk("no_write", exp_wr, i_flash.n_wr);
    stop_test();
  end
endmodule : spc_ctrl_tb
